// [core/pmhs_ctrl.v]
/*
 Controller that drives a twenty-head read/write preamplifier through its
 mode, head-select, write data, servo and supply-sequencing pins, ordered by
 software over an APB slave with its own register file and one interrupt.
 Assumes a 250 MHz clock, an asynchronous active-low reset, and that the
 supply and pull-up outputs steer external switches.
*/
// How it works
// - After the flag clears, two falling data edges are given before trusting it.
// - Pin servo entry lowers the high supply before driving servo enable low.
// - Resistor entry: lower supply, then read mode, then pull-up above logic supply.
// - Leaving servo: read mode, pull-up back, supply raised, then write allowed.
`default_nettype none
`include "pmhs_map.vh"

module pmhs_ctrl #(
   parameter integer SETTLE_CYCLES = `PMHS_SETTLE_CYCLES,
   parameter integer TOGGLE_CYCLES = `PMHS_TOGGLE_CYCLES
) (
   input  wire        CLK_IN,
   input  wire        ARST_N_IN,
   input  wire        CE_IN,
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [7:0]  PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output reg         PREADY_OUT,
   output reg  [31:0] PRDATA_OUT,
   output reg         PSLVERR_OUT,
   output reg         IRQ_OUT,
   input  wire        WRITE_UNSAFE_FLAG_IN,
   output reg         SLEEP_SEL_OUT,
   output reg         READ_NOT_WRITE_OUT,
   output reg  [4:0]  HEAD_INDEX_LINES_OUT,
   output reg         WRITE_DATA_POS_OUT,
   output reg         WRITE_DATA_NEG_OUT,
   output reg         SERVO_ENABLE_N_OUT,
   output reg         QUAD_BANK_SEL_N_OUT,
   output reg         HIGH_SUPPLY_LOW_OUT,
   output reg         UNSAFE_PULLUP_HI_OUT
);

   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_LOWER  = 3'h1;
   localparam [2:0] ST_ARM    = 3'h2;
   localparam [2:0] ST_ACTIVE = 3'h3;
   localparam [2:0] ST_EXIT   = 3'h4;
   localparam [2:0] ST_RAISE  = 3'h5;
   localparam integer TW = 16;

   reg  [2:0]                ctrl;
   reg  [`PMHS_HEAD_W-1:0]   head;
   reg  [4:0]                servo;
   reg  [`PMHS_IRQ_W-1:0]    irq_stat;
   reg  [`PMHS_IRQ_W-1:0]    irq_mask;
   reg  [2:0]                state;
   reg  [2:0]                next_state;
   reg  [TW-1:0]             timer;
   reg                       unsafe_meta;
   reg                       unsafe;
   reg                       unsafe_d;
   reg                       trusted_d;
   reg                       toggle;
   reg  [`PMHS_IRQ_W-1:0]    next_irq;
   reg  [31:0]               rdata;
   reg                       hit;
   wire                      wd_level;
   wire [1:0]                neg_count;
   wire                      acc;
   wire                      wr;
   wire                      settled;
   wire                      force_read;
   wire                      in_servo;
   wire                      trusted;
   wire                      write_mode;
   wire [`PMHS_IRQ_W-1:0]    w1c;
   wire [`PMHS_HEAD_W-1:0]   servo_lines;

   assign acc        = PSEL_IN && PENABLE_IN && !PREADY_OUT;
   assign wr         = acc && PWRITE_IN;
   assign settled    = (timer == SETTLE_CYCLES[TW-1:0] - 16'h0001);
   assign in_servo   = (state == ST_ARM) || (state == ST_ACTIVE);
   // Resistor entry holds read mode through arming and servo; any exit forces read.
   assign force_read = (servo[`PMHS_SERVO_RES] && in_servo) || (state == ST_EXIT) || (state == ST_RAISE);
   assign write_mode = !ctrl[`PMHS_CTRL_SLEEP] && !(ctrl[`PMHS_CTRL_RNW] || force_read);
   assign trusted    = !unsafe && (neg_count == `PMHS_NEG_NEEDED);
   assign w1c        = (wr && PADDR_IN == `PMHS_OFF_IRQ_STAT) ? PWDATA_IN[`PMHS_IRQ_W-1:0] : 4'h0;
   // Quad bank puts the two-bit code on lines 1:0; dual bank uses line 0 alone.
   assign servo_lines = servo[`PMHS_SERVO_QUAD] ?
                        {head[4:2], servo[`PMHS_SERVO_BANK_LO+1], servo[`PMHS_SERVO_BANK_LO]} :
                        {head[4:1], servo[`PMHS_SERVO_BANK_LO]};

   pmhs_wdgen #(
      .TOGGLE_CYCLES (TOGGLE_CYCLES),
      .CNT_W         (8)
   ) u_wdgen (
      .clk_in        (CLK_IN),
      .arst_n_in     (ARST_N_IN),
      .ce_in         (CE_IN),
      .auto_en_in    (ctrl[`PMHS_CTRL_AUTO]),
      .toggle_in     (toggle),
      .clear_in      (unsafe),
      .level_out     (wd_level),
      .neg_count_out (neg_count)
   );

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (servo[`PMHS_SERVO_REQ]) begin
               next_state = ST_LOWER;
            end
         end
         ST_LOWER: begin
            if (settled) begin
               next_state = ST_ARM;
            end
         end
         ST_ARM: begin
            if (settled) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_ACTIVE: begin
            if (!servo[`PMHS_SERVO_REQ]) begin
               next_state = ST_EXIT;
            end
         end
         ST_EXIT: begin
            if (settled) begin
               next_state = ST_RAISE;
            end
         end
         ST_RAISE: begin
            if (settled) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always @* begin
      next_irq = irq_stat & ~w1c;
      // Events are set after the clear so a same-cycle event is kept.
      if (unsafe && !unsafe_d && write_mode) begin
         next_irq[`PMHS_IRQ_UNSAFE] = 1'b1;
      end
      if (trusted && !trusted_d) begin
         next_irq[`PMHS_IRQ_TRUSTED] = 1'b1;
      end
      if ((state == ST_ARM && next_state == ST_ACTIVE) || (state == ST_RAISE && next_state == ST_IDLE)) begin
         next_irq[`PMHS_IRQ_SERVO] = 1'b1;
      end
      if (wr && PADDR_IN == `PMHS_OFF_HEAD && PWDATA_IN[`PMHS_HEAD_W-1:0] > `PMHS_HEAD_MAX) begin
         next_irq[`PMHS_IRQ_HEAD_ERR] = 1'b1;
      end
   end

   always @* begin
      hit   = 1'b1;
      rdata = 32'h0000_0000;
      case (PADDR_IN)
         `PMHS_OFF_CTRL:     rdata[2:0] = ctrl;
         `PMHS_OFF_HEAD:     rdata[`PMHS_HEAD_W-1:0] = head;
         `PMHS_OFF_WDATA:    rdata[0] = wd_level;
         `PMHS_OFF_SERVO:    rdata[4:0] = servo;
         `PMHS_OFF_STATUS:   rdata[7:0] = {neg_count, in_servo, state, trusted, unsafe};
         `PMHS_OFF_IRQ_STAT: rdata[`PMHS_IRQ_W-1:0] = irq_stat;
         `PMHS_OFF_IRQ_MASK: rdata[`PMHS_IRQ_W-1:0] = irq_mask;
         default:            hit = 1'b0;
      endcase
   end

   always @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         ctrl                 <= `PMHS_CTRL_RST;
         head                 <= `PMHS_HEAD_RST;
         servo                <= `PMHS_SERVO_RST;
         irq_stat             <= 4'h0;
         irq_mask             <= 4'h0;
         state                <= ST_IDLE;
         timer                <= 16'h0000;
         unsafe_meta          <= 1'b1;
         unsafe               <= 1'b1;
         unsafe_d             <= 1'b1;
         trusted_d            <= 1'b0;
         toggle               <= 1'b0;
         PREADY_OUT           <= 1'b0;
         PRDATA_OUT           <= 32'h0000_0000;
         PSLVERR_OUT          <= 1'b0;
         IRQ_OUT              <= 1'b0;
         SLEEP_SEL_OUT        <= 1'b1;
         READ_NOT_WRITE_OUT   <= 1'b1;
         HEAD_INDEX_LINES_OUT <= 5'h00;
         WRITE_DATA_POS_OUT   <= 1'b1;
         WRITE_DATA_NEG_OUT   <= 1'b0;
         SERVO_ENABLE_N_OUT   <= 1'b1;
         QUAD_BANK_SEL_N_OUT  <= 1'b1;
         HIGH_SUPPLY_LOW_OUT  <= 1'b0;
         UNSAFE_PULLUP_HI_OUT <= 1'b0;
      end else if (CE_IN) begin
         unsafe_meta <= WRITE_UNSAFE_FLAG_IN;
         unsafe      <= unsafe_meta;
         unsafe_d    <= unsafe;
         trusted_d   <= trusted;
         PREADY_OUT  <= acc;
         PSLVERR_OUT <= acc && !hit;
         PRDATA_OUT  <= (acc && !PWRITE_IN) ? rdata : 32'h0000_0000;
         toggle      <= wr && PADDR_IN == `PMHS_OFF_WDATA && PWDATA_IN[`PMHS_WDATA_TOGGLE];
         if (wr && PADDR_IN == `PMHS_OFF_CTRL) begin
            ctrl <= PWDATA_IN[2:0];
         end
         if (wr && PADDR_IN == `PMHS_OFF_HEAD && PWDATA_IN[`PMHS_HEAD_W-1:0] <= `PMHS_HEAD_MAX) begin
            head <= PWDATA_IN[`PMHS_HEAD_W-1:0];
         end
         if (wr && PADDR_IN == `PMHS_OFF_SERVO) begin
            servo <= PWDATA_IN[4:0];
         end
         if (wr && PADDR_IN == `PMHS_OFF_IRQ_MASK) begin
            irq_mask <= PWDATA_IN[`PMHS_IRQ_W-1:0];
         end
         irq_stat <= next_irq;
         IRQ_OUT  <= |(next_irq & irq_mask);
         state    <= next_state;
         timer    <= (next_state != state || settled) ? 16'h0000 : timer + 16'h0001;
         SLEEP_SEL_OUT        <= ctrl[`PMHS_CTRL_SLEEP];
         // High read-not-write disarms write current and the unsafe detector.
         READ_NOT_WRITE_OUT   <= ctrl[`PMHS_CTRL_RNW] || force_read;
         HEAD_INDEX_LINES_OUT <= (state == ST_ACTIVE) ? servo_lines : head;
         WRITE_DATA_POS_OUT   <= wd_level;
         WRITE_DATA_NEG_OUT   <= ~wd_level;
         // Supply goes low before any servo arming and returns only after disarm.
         HIGH_SUPPLY_LOW_OUT  <= (state != ST_IDLE) && (state != ST_RAISE);
         SERVO_ENABLE_N_OUT   <= !(state == ST_ACTIVE && !servo[`PMHS_SERVO_RES]);
         UNSAFE_PULLUP_HI_OUT <= (state == ST_ACTIVE) && servo[`PMHS_SERVO_RES];
         QUAD_BANK_SEL_N_OUT  <= !servo[`PMHS_SERVO_QUAD];
      end
   end

endmodule // pmhs_ctrl

`default_nettype wire

// [core/pmhs_map.vh]
/*
 Register map, field positions, reset values and timing counts of the
 preamplifier mode and head-select controller.
 Assumes it is included by bare name from the core design files.
*/
`ifndef PMHS_MAP_VH
`define PMHS_MAP_VH

`define PMHS_ADDR_W            8
`define PMHS_OFF_CTRL          8'h00
`define PMHS_OFF_HEAD          8'h04
`define PMHS_OFF_WDATA         8'h08
`define PMHS_OFF_SERVO         8'h0c
`define PMHS_OFF_STATUS        8'h10
`define PMHS_OFF_IRQ_STAT      8'h14
`define PMHS_OFF_IRQ_MASK      8'h18

`define PMHS_CTRL_SLEEP        0
`define PMHS_CTRL_RNW          1
`define PMHS_CTRL_AUTO         2
`define PMHS_CTRL_RST          3'h3

`define PMHS_HEAD_W            5
`define PMHS_HEAD_MAX          5'h13
`define PMHS_HEAD_RST          5'h00

`define PMHS_WDATA_TOGGLE      0

`define PMHS_SERVO_REQ         0
`define PMHS_SERVO_RES         1
`define PMHS_SERVO_QUAD        2
`define PMHS_SERVO_BANK_LO     3
`define PMHS_SERVO_RST         5'h00

`define PMHS_IRQ_W             4
`define PMHS_IRQ_UNSAFE        0
`define PMHS_IRQ_TRUSTED       1
`define PMHS_IRQ_SERVO         2
`define PMHS_IRQ_HEAD_ERR      3

`define PMHS_NEG_NEEDED        2'h2

`define PMHS_CLK_PERIOD_NS     4
`define PMHS_SETTLE_NS         1000
`define PMHS_SETTLE_CYCLES     ((`PMHS_SETTLE_NS + `PMHS_CLK_PERIOD_NS - 1) / `PMHS_CLK_PERIOD_NS)
`define PMHS_TOGGLE_NS         100
`define PMHS_TOGGLE_CYCLES     (`PMHS_TOGGLE_NS / `PMHS_CLK_PERIOD_NS)

`endif

// [core/pmhs_wdgen.v]
/*
 Write data generator: holds the write data level, toggles it on command or
 periodically, and counts negative transitions since the last clear.
 Assumes a single clock and a clock enable that freezes all state.
*/
`default_nettype none
`include "pmhs_map.vh"

module pmhs_wdgen #(
   parameter integer TOGGLE_CYCLES = `PMHS_TOGGLE_CYCLES,
   parameter integer CNT_W         = 8
) (
   input  wire       clk_in,
   input  wire       arst_n_in,
   input  wire       ce_in,
   input  wire       auto_en_in,
   input  wire       toggle_in,
   input  wire       clear_in,
   output reg        level_out,
   output reg  [1:0] neg_count_out
);

   reg [CNT_W-1:0] div;
   wire            tick;
   wire            flip;

   assign tick = auto_en_in && (div == TOGGLE_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});
   assign flip = toggle_in || tick;

   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div           <= {CNT_W{1'b0}};
         level_out     <= 1'b1;
         neg_count_out <= 2'h0;
      end else if (ce_in) begin
         if (!auto_en_in || tick) begin
            div <= {CNT_W{1'b0}};
         end else begin
            div <= div + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         if (flip) begin
            level_out <= ~level_out;
         end
         // Counting saturates at the number of falling edges the flag needs.
         if (clear_in) begin
            neg_count_out <= 2'h0;
         end else if (flip && level_out && neg_count_out != `PMHS_NEG_NEEDED) begin
            neg_count_out <= neg_count_out + 2'h1;
         end
      end
   end

endmodule // pmhs_wdgen

`default_nettype wire

// [tb/pmhs_ctrl_asserts.sv]
/*
 Checker of the controller's pin ordering and bus answers.
 Assumes it is bound to the controller and sees only its ports.
*/
`default_nettype none
module pmhs_ctrl_asserts (
   input wire logic       CLK_IN,
   input wire logic       ARST_N_IN,
   input wire logic       CE_IN,
   input wire logic       PSEL_IN,
   input wire logic       PENABLE_IN,
   input wire logic [7:0] PADDR_IN,
   input wire logic       PREADY_OUT,
   input wire logic       PSLVERR_OUT,
   input wire logic       SLEEP_SEL_OUT,
   input wire logic       READ_NOT_WRITE_OUT,
   input wire logic       WRITE_DATA_POS_OUT,
   input wire logic       WRITE_DATA_NEG_OUT,
   input wire logic       SERVO_ENABLE_N_OUT,
   input wire logic       HIGH_SUPPLY_LOW_OUT,
   input wire logic       UNSAFE_PULLUP_HI_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   a_wd_pair: assert property (WRITE_DATA_POS_OUT != WRITE_DATA_NEG_OUT)
      else $error("write data pair not complementary");
   a_servo_supply: assert property (!SERVO_ENABLE_N_OUT |-> HIGH_SUPPLY_LOW_OUT)
      else $error("servo enable without lowered supply");
   a_pullup_read: assert property (UNSAFE_PULLUP_HI_OUT |-> HIGH_SUPPLY_LOW_OUT && READ_NOT_WRITE_OUT)
      else $error("pull-up raised outside read at low supply");
   a_pullup_order: assert property ($rose(UNSAFE_PULLUP_HI_OUT) |-> $past(READ_NOT_WRITE_OUT, 2))
      else $error("pull-up raised before read mode");
   a_write_exit: assert property ($fell(READ_NOT_WRITE_OUT) |-> !$past(UNSAFE_PULLUP_HI_OUT))
      else $error("write entered with pull-up high");
   a_supply_raise: assert property ($fell(HIGH_SUPPLY_LOW_OUT) |-> $past(SERVO_ENABLE_N_OUT) && !UNSAFE_PULLUP_HI_OUT)
      else $error("supply raised while servo active");
   a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready longer than one cycle");
   a_ready_time: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT && CE_IN |=> PREADY_OUT)
      else $error("ready late");
   a_err_unmap: assert property (PREADY_OUT && PADDR_IN[1:0] == 2'h0 |-> PSLVERR_OUT == (PADDR_IN > 8'h18))
      else $error("wrong slave error");
   a_reset_safe: assert property ($rose(ARST_N_IN) |-> SLEEP_SEL_OUT && READ_NOT_WRITE_OUT)
      else $error("not idle after reset");
   c_servo_pin: cover property (!SERVO_ENABLE_N_OUT);
   c_servo_res: cover property (UNSAFE_PULLUP_HI_OUT);
   c_slverr: cover property (PREADY_OUT && PSLVERR_OUT);
endmodule // pmhs_ctrl_asserts
bind pmhs_ctrl pmhs_ctrl_asserts u_pmhs_ctrl_asserts (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .CE_IN(CE_IN),
   .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT), .SLEEP_SEL_OUT(SLEEP_SEL_OUT), .READ_NOT_WRITE_OUT(READ_NOT_WRITE_OUT),
   .WRITE_DATA_POS_OUT(WRITE_DATA_POS_OUT), .WRITE_DATA_NEG_OUT(WRITE_DATA_NEG_OUT),
   .SERVO_ENABLE_N_OUT(SERVO_ENABLE_N_OUT), .HIGH_SUPPLY_LOW_OUT(HIGH_SUPPLY_LOW_OUT),
   .UNSAFE_PULLUP_HI_OUT(UNSAFE_PULLUP_HI_OUT));
`default_nettype wire

// [tb/pmhs_dev_model.sv]
/*
 Behavioural preamplifier that answers the controller with its unsafe flag.
 Assumes the controller drives every mode, data and supply pin.
*/
`default_nettype none
module pmhs_dev_model (
   input  wire logic sleep_sel_in,
   input  wire logic read_not_write_in,
   input  wire logic write_data_pos_in,
   input  wire logic servo_enable_n_in,
   input  wire logic high_supply_low_in,
   input  wire logic unsafe_pullup_hi_in,
   input  wire logic fault_in,
   output var  logic write_unsafe_flag_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       servo;
   logic       bad;
   logic [1:0] neg_cnt = 2'h0;
   assign servo = high_supply_low_in & (!servo_enable_n_in | unsafe_pullup_hi_in);
   assign bad = sleep_sel_in | read_not_write_in | fault_in | servo;
   always @(negedge write_data_pos_in or posedge bad) begin
      if (bad)
         neg_cnt <= 2'h0;
      else if (neg_cnt != 2'h2)
         neg_cnt <= neg_cnt + 2'h1;
   end
   assign write_unsafe_flag_out = bad | (neg_cnt != 2'h2);
endmodule // pmhs_dev_model
`default_nettype wire

// [tb/tb_pmhs_ctrl.sv]
/*
 Self-checking bench of the controller against a behavioural preamplifier.
 Assumes short settle and toggle counts so the run stays brief.
*/
`default_nettype none
module tb_pmhs_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] pins; logic [7:0] rd;} pmhs_row_t;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fault = 1'b0, ce = 1'b1;
   logic [1:0] wsnap;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic prdy, perr, irq, unsafe, sleep, rnw, wdp, wdn, sen_n, qb_n, slow, pup, rerr;
   logic [4:0] head;
   int mismatches = 0;
   int n_tests = 0;
   pmhs_row_t rows [6] = '{'{8'h00, 8'h01, 8'h40, 8'h01}, '{8'h00, 8'h02, 8'h20, 8'h02},
      '{8'h00, 8'h00, 8'h00, 8'h00}, '{8'h04, 8'h13, 8'h13, 8'h13}, '{8'h04, 8'h05, 8'h05, 8'h05},
      '{8'h04, 8'h14, 8'h05, 8'h05}};
   always #2 clk = ~clk;
   pmhs_ctrl #(.SETTLE_CYCLES(4), .TOGGLE_CYCLES(3)) u_pmhs_ctrl (.CLK_IN(clk), .ARST_N_IN(rst_n), .CE_IN(ce),
      .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PREADY_OUT(prdy), .PRDATA_OUT(prdata), .PSLVERR_OUT(perr), .IRQ_OUT(irq), .WRITE_UNSAFE_FLAG_IN(unsafe),
      .SLEEP_SEL_OUT(sleep), .READ_NOT_WRITE_OUT(rnw), .HEAD_INDEX_LINES_OUT(head), .WRITE_DATA_POS_OUT(wdp),
      .WRITE_DATA_NEG_OUT(wdn), .SERVO_ENABLE_N_OUT(sen_n), .QUAD_BANK_SEL_N_OUT(qb_n),
      .HIGH_SUPPLY_LOW_OUT(slow), .UNSAFE_PULLUP_HI_OUT(pup));
   pmhs_dev_model u_pmhs_dev_model (.sleep_sel_in(sleep), .read_not_write_in(rnw), .write_data_pos_in(wdp),
      .servo_enable_n_in(sen_n), .high_supply_low_in(slow), .unsafe_pullup_hi_in(pup), .fault_in(fault),
      .write_unsafe_flag_out(unsafe));
   task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (prdy !== 1'b1);
      rdat = prdata;
      rerr = perr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      mismatches++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset pins", {1'b0, sleep, rnw, head}, 8'h60);
      chk("reset servo", {4'h0, sen_n, slow, pup, wdp}, 8'h09);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         chk("mode pins", {1'b0, sleep, rnw, head}, rows[i].pins);
         apb(1'b0, rows[i].a, 8'h00);
         chk("readback", rdat[7:0], rows[i].rd);
      end
      apb(1'b0, 8'h40, 8'h00);
      chk("slverr", {rerr, rdat[6:0]}, 8'h80);
      apb(1'b1, 8'h08, 8'h01);
      repeat (2) @(posedge clk);
      chk("wd pair", {6'h0, wdp, wdn}, 8'h01);
      apb(1'b1, 8'h00, 8'h04);
      repeat (80) @(posedge clk);
      apb(1'b0, 8'h10, 8'h00);
      chk("trusted", rdat[7:0] & 8'h03, 8'h02);
      apb(1'b0, 8'h14, 8'h00);
      chk("irq stat", rdat[7:0] & 8'h0a, 8'h0a);
      chk("irq masked", {7'h0, irq}, 8'h00);
      apb(1'b1, 8'h18, 8'h02);
      chk("irq on", {7'h0, irq}, 8'h01);
      apb(1'b1, 8'h14, 8'h0f);
      chk("irq clear", {7'h0, irq}, 8'h00);
      apb(1'b1, 8'h18, 8'h01);
      fault <= 1'b1;
      repeat (10) @(posedge clk);
      chk("fault irq", {7'h0, irq}, 8'h01);
      fault <= 1'b0;
      apb(1'b1, 8'h14, 8'h0f);
      chk("fault clear", {7'h0, irq}, 8'h00);
      apb(1'b1, 8'h00, 8'h02);
      repeat (10) @(posedge clk);
      apb(1'b0, 8'h10, 8'h00);
      chk("read unsafe", rdat[7:0] & 8'h03, 8'h01);
      apb(1'b1, 8'h0c, 8'h15);
      repeat (40) @(posedge clk);
      chk("servo pin", {3'h0, sen_n, slow, qb_n, head[1:0]}, 8'h0a);
      apb(1'b0, 8'h14, 8'h00);
      chk("servo irq", rdat[7:0] & 8'h04, 8'h04);
      apb(1'b1, 8'h0c, 8'h14);
      repeat (40) @(posedge clk);
      chk("servo off", {6'h0, sen_n, slow}, 8'h02);
      apb(1'b1, 8'h0c, 8'h0b);
      repeat (40) @(posedge clk);
      chk("servo res", {3'h0, pup, rnw, qb_n, head[0], slow}, 8'h1f);
      apb(1'b1, 8'h0c, 8'h0a);
      repeat (40) @(posedge clk);
      chk("res off", {6'h0, pup, slow}, 8'h00);
      apb(1'b1, 8'h00, 8'h06);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      wsnap = {wdp, wdn};
      repeat (9) @(posedge clk);
      chk("ce freeze", {6'h0, wdp, wdn}, {6'h0, wsnap});
      ce <= 1'b1;
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset again", {1'b0, sleep, rnw, head}, 8'h60);
      chk("reset again wd", {6'h0, wdp, wdn}, 8'h02);
      final_report();
   end
endmodule // tb_pmhs_ctrl
`default_nettype wire
